//--- lbus_memory_model.sv
// Purpose: Memory partner answering the local bus with programmable waits.
// Assumes: Sixteen words; address bits 5:2 pick the word.
// Notes: Undriven data lines toggle each cycle so stale values never pass.
`timescale 1ns/1ps
module lbus_memory_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] bus_out_i,
    input wire logic bus_oe_i,
    input wire logic strobe_n_i,
    input wire logic data_enable_n_i,
    input wire logic write_i,
    input wire logic [1:0] wait_cycles_i,
    input wire logic bad_req_i,
    output logic [31:0] bus_in_o,
    output logic ready_n_o,
    output logic bad_n_o
);
    logic [31:0] mem [16];
    logic [31:0] last_ff;
    logic [3:0] word_ff;
    logic [1:0] wait_ff;
    logic ready_seen_ff;
    assign ready_n_o = !(!data_enable_n_i && wait_ff == wait_cycles_i);
    assign bus_in_o = bus_oe_i ? bus_out_i : (!data_enable_n_i && !write_i) ? mem[word_ff] : ~last_ff;
    assign bad_n_o = !(bad_req_i && ready_seen_ff);
    initial for (int i = 0; i < 16; i++) mem[i] = 32'ha5a50000 + i;
    // Address capture, word stepping and write storage.
    always @(posedge clk_i) begin
        ready_seen_ff <= !ready_n_o;
        last_ff <= rst_n_i ? bus_in_o : 32'h0;
        if (!rst_n_i) wait_ff <= 2'h0;
        else if (!strobe_n_i && data_enable_n_i) word_ff <= bus_out_i[5:2];
        else if (!ready_n_o) begin
            if (write_i) mem[word_ff] <= bus_out_i;
            word_ff <= word_ff + 4'h1;
            wait_ff <= 2'h0;
        end else if (!data_enable_n_i) wait_ff <= wait_ff + 2'h1;
    end
endmodule : lbus_memory_model

//--- local_bus_interface.sv
// Purpose: Processor side of a multiplexed 32-bit local bus.
// Assumes: All inputs synchronous to clk_i; active-low pins are named _n.
// Notes: Byte enables for later words come from the core as it consumes data.
// How it works
// - Address cycle carries burst length code
// - Latch enable low only in address cycle
// - Address strobe every address state
// - Strobe again after each ready in burst
// - Write/read qualifier latched through data cycles
// - Direction steady, low read or acknowledge, high other write
// - Data enable during data cycles
// - No ready means wait, no strobe
// - Locked read waits for free lock
// - Locked write releases lock at address
// - Lock held through interrupt acknowledge
// - Four active-low byte enables, high lane top
// - Byte enables one word ahead, held
// - Enables adjacent, aligned, at least one; checked for first word only
// - Primary master floats, acknowledges, holds
// - Secondary master requests, owns when granted
// - First interrupt pin at reset sets role
// - Cacheable flag, never synchronous, floats idle
// - Bad access sampled after last ready
// - Bad access at reset selects initializer
// - Reset ignores inputs, floats, deasserts outputs
// - Failure during self-test and bad checksum
// - Config selects third and fourth pin use
`timescale 1ns/1ps
module local_bus_interface
    import local_bus_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Core request side.
    input wire logic req_valid_i,
    input wire bus_req_t req_i,
    input wire logic [3:0] first_byte_enables_n_i,
    input wire logic [3:0] next_byte_enables_n_i,
    input wire logic [31:0] write_data_i,
    input wire logic [31:0] next_write_data_i,
    output logic req_ready_o,
    output logic [31:0] read_data_o,
    output logic read_data_valid_o,
    output logic done_o,
    output logic bus_error_o,
    // Configuration for pins three and four.
    input wire logic third_is_controller_request_i,
    input wire logic fourth_is_acknowledge_i,
    // Self-test result, and checksum result from the core after boot reads.
    input wire logic self_test_pass_i,
    input wire logic checksum_done_i,
    input wire logic checksum_zero_i,
    // Bus pins.
    input wire logic [31:0] address_data_lines_i,
    output logic [31:0] address_data_lines_o,
    output logic address_data_lines_oe_o,
    output logic address_latch_enable_n_o,
    output logic address_latch_enable_oe_o,
    output logic address_strobe_n_o,
    output logic write_read_o,
    output logic transfer_direction_o,
    output logic data_enable_strobe_n_o,
    input wire logic ready_n_i,
    input wire logic lock_n_i,
    output logic lock_n_oe_o,
    output logic [3:0] byte_enables_n_o,
    input wire logic hold_request_or_grant_in_i,
    output logic hold_grant_or_request_out_o,
    output logic hold_grant_or_request_out_oe_o,
    output logic cache_o,
    output logic cache_oe_o,
    input wire logic bad_access_input_n_i,
    output logic failure_n_o,
    input wire logic agent_request_interrupt_first_n_i,
    input wire logic interrupt_second_i,
    input wire logic interrupt_third_or_controller_request_i,
    input wire logic interrupt_fourth_or_acknowledge_n_i,
    output logic interrupt_fourth_or_acknowledge_oe_o,
    // Captured roles and interrupt events toward the core.
    output logic primary_master_role_o,
    output logic local_number_o,
    output logic performs_init_o,
    output logic [3:0] interrupt_event_o,
    output logic controller_request_o
);
    // -------------------------------------------------------------------------
    // State record
    // -------------------------------------------------------------------------
    typedef struct packed {
        bus_state_t st;
        boot_state_t boot;
        logic [7:0] test_cnt;
        logic [1:0] beats_left;
        bus_req_t req;
        logic in_reset;
        logic primary;
        logic init_self;
        logic [3:0] int_prev;
        logic [3:0] int_evt;
        logic ctrl_req;
        logic lock_held;
        logic bad_check;
        logic req_ready;
        logic [31:0] rdata;
        logic rvalid;
        logic done;
        logic berr;
        bus_word_drive_t address_data_lines;
        logic ale_n;
        logic ale_oe;
        logic ads_n;
        logic wr;
        logic dir;
        logic den_n;
        logic [3:0] be_n;
        logic hold_out;
        logic hold_oe;
        logic cache;
        logic cache_oe;
        logic fail_n;
        logic inta_oe;
    } state_t;

    state_t cur_ff; // Registered state, every output comes from here.
    state_t nxt_ff; // Next value built combinationally.

    // Raw interrupt levels, active high, in pin order.
    logic [3:0] int_level;
    assign int_level = {~interrupt_fourth_or_acknowledge_n_i, interrupt_third_or_controller_request_i,
                        interrupt_second_i, ~agent_request_interrupt_first_n_i};

    // Legal pattern check: adjacent, naturally aligned, at least one byte.
    function automatic logic be_legal(input logic [3:0] be_n);
        logic [3:0] be;
        be = ~be_n;
        be_legal = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) || (be == 4'h8) ||
                   (be == 4'h3) || (be == 4'hc) || (be == 4'hf);
    endfunction : be_legal

    // Bus ownership: primary owns unless holding, secondary when granted.
    logic owns_bus;
    assign owns_bus = cur_ff.primary ? (cur_ff.st != ST_HOLD)
                                     : (cur_ff.hold_out && hold_request_or_grant_in_i);

    // -------------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------------
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rvalid = 1'b0;
        nxt_ff.done = 1'b0;
        nxt_ff.berr = 1'b0;
        nxt_ff.in_reset = 1'b0;
        nxt_ff.req_ready = 1'b0;

        // Interrupt edges: a deasserted-then-asserted sequence is an event.
        // Synchronous inputs, so one cycle each suffices as required.
        // edge qualifies interrupt
        nxt_ff.int_prev = int_level;
        nxt_ff.int_evt = int_level & ~cur_ff.int_prev;
        if (third_is_controller_request_i) begin
            nxt_ff.int_evt[2] = 1'b0;
            nxt_ff.ctrl_req = interrupt_third_or_controller_request_i;
        end else begin
            nxt_ff.ctrl_req = 1'b0;
        end
        // A fourth pin used as acknowledge is an output, never an interrupt.
        if (fourth_is_acknowledge_i) begin
            nxt_ff.int_evt[3] = 1'b0;
        end

        // Self-test runs before any bus transaction is allowed; checksum reads use the bus.
        // self-test and checksum
        unique case (cur_ff.boot)
            BOOT_TEST: begin
                nxt_ff.fail_n = 1'b0;
                if (cur_ff.test_cnt != SELF_TEST_CYCLES) begin
                    nxt_ff.test_cnt = cur_ff.test_cnt + 8'h01;
                end else if (self_test_pass_i) begin
                    nxt_ff.fail_n = 1'b1;
                    nxt_ff.boot = BOOT_SUM;
                end else begin
                    nxt_ff.boot = BOOT_FAIL;
                end
            end
            BOOT_SUM: begin
                // Core reads CHECKSUM_WORDS words over the bus and reports.
                nxt_ff.bad_check = (CHECKSUM_WORDS == 4'h0);
                if (checksum_done_i) begin
                    if (checksum_zero_i && !cur_ff.bad_check) begin
                        nxt_ff.boot = BOOT_RUN;
                    end else begin
                        nxt_ff.fail_n = 1'b0;
                        nxt_ff.boot = BOOT_FAIL;
                    end
                end
            end
            BOOT_RUN: begin
                nxt_ff.fail_n = 1'b1;
            end
            BOOT_FAIL: begin
                // Failure stays asserted until the next reset.
                nxt_ff.fail_n = 1'b0;
            end
        endcase

        // Bus cycle machine.
        unique case (cur_ff.st)
            ST_IDLE: begin
                // Strobes idle high; address/data, latch enable, cache and acknowledge lines float when idle, hold output stays driven.
                nxt_ff.ads_n = 1'b1;
                nxt_ff.den_n = 1'b1;
                nxt_ff.ale_oe = 1'b0;
                nxt_ff.address_data_lines.enable = 1'b0;
                nxt_ff.cache_oe = 1'b0;
                nxt_ff.be_n = BYTE_ENABLES_IDLE;
                nxt_ff.inta_oe = 1'b0;
                if (cur_ff.primary && hold_request_or_grant_in_i) begin
                    nxt_ff.hold_out = 1'b1;
                    nxt_ff.st = ST_HOLD;
                end else begin
                    if (!cur_ff.primary) begin
                        nxt_ff.hold_out = req_valid_i && (cur_ff.boot != BOOT_FAIL);
                    end
                    if (req_valid_i && owns_bus && cur_ff.boot inside {BOOT_SUM, BOOT_RUN} && !cur_ff.req_ready &&
                        !(req_i.locked_read_modify_write && !lock_n_i && !cur_ff.lock_held) &&
                        be_legal(first_byte_enables_n_i)) begin
                        nxt_ff.req_ready = 1'b1;
                        nxt_ff.req = req_i;
                        nxt_ff.st = ST_ADDR;
                        nxt_ff.beats_left = req_i.size;
                        nxt_ff.address_data_lines.value = {req_i.word_addr, req_i.size};
                        nxt_ff.address_data_lines.enable = 1'b1;
                        nxt_ff.ale_n = 1'b0;
                        nxt_ff.ale_oe = 1'b1;
                        nxt_ff.ads_n = 1'b0;
                        nxt_ff.wr = req_i.write;
                        nxt_ff.dir = req_i.write && !req_i.int_ack;
                        nxt_ff.be_n = first_byte_enables_n_i;
                        nxt_ff.cache = req_i.cacheable && !req_i.synchronous;
                        nxt_ff.cache_oe = 1'b1;
                        nxt_ff.inta_oe = fourth_is_acknowledge_i && req_i.int_ack;
                        if (req_i.locked_read_modify_write || req_i.int_ack) begin
                            nxt_ff.lock_held = 1'b1;
                        end else if (req_i.rmw_write) begin
                            nxt_ff.lock_held = 1'b0;
                        end
                    end
                end
            end
            ST_ADDR: begin
                nxt_ff.ale_n = 1'b1;
                nxt_ff.ads_n = 1'b1;
                nxt_ff.den_n = 1'b0;
                nxt_ff.address_data_lines.value = write_data_i;
                nxt_ff.address_data_lines.enable = cur_ff.req.write;
                nxt_ff.be_n = next_byte_enables_n_i;
                nxt_ff.st = ST_DATA;
            end
            ST_DATA: begin
                if (!ready_n_i) begin
                    if (!cur_ff.req.write) begin
                        nxt_ff.rdata = address_data_lines_i;
                        nxt_ff.rvalid = 1'b1;
                    end
                    if (cur_ff.beats_left == BEAT_RESET) begin
                        nxt_ff.den_n = 1'b1;
                        nxt_ff.ads_n = 1'b1;
                        nxt_ff.address_data_lines.enable = 1'b0;
                        nxt_ff.st = ST_RECOVER;
                    end else begin
                        nxt_ff.ads_n = 1'b0;
                        nxt_ff.beats_left = cur_ff.beats_left - 2'h1;
                        nxt_ff.address_data_lines.value = next_write_data_i;
                        nxt_ff.be_n = next_byte_enables_n_i;
                    end
                end else begin
                    nxt_ff.ads_n = 1'b1;
                end
            end
            ST_RECOVER: begin
                nxt_ff.berr = !bad_access_input_n_i;
                nxt_ff.done = 1'b1;
                nxt_ff.cache_oe = 1'b0;
                nxt_ff.ale_oe = 1'b0;
                nxt_ff.inta_oe = 1'b0;
                nxt_ff.lock_held = cur_ff.lock_held && !cur_ff.req.int_ack;
                nxt_ff.be_n = BYTE_ENABLES_IDLE;
                nxt_ff.st = ST_IDLE;
            end
            ST_HOLD: begin
                if (!hold_request_or_grant_in_i) begin
                    nxt_ff.hold_out = 1'b0;
                    nxt_ff.st = ST_IDLE;
                end
            end
            default: begin
                nxt_ff.st = ST_IDLE;
            end
        endcase
        nxt_ff.hold_oe = 1'b1;
    end

    // -------------------------------------------------------------------------
    // Register and reset
    // -------------------------------------------------------------------------
    // Straps are captured while reset is low; other inputs are ignored then.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cur_ff <= '0;
            cur_ff.st <= ST_IDLE;
            cur_ff.boot <= BOOT_TEST;
            cur_ff.in_reset <= 1'b1;
            cur_ff.ale_n <= 1'b1;
            cur_ff.ads_n <= 1'b1;
            cur_ff.den_n <= 1'b1;
            cur_ff.be_n <= BYTE_ENABLES_IDLE;
            cur_ff.fail_n <= 1'b1;
            cur_ff.beats_left <= BEAT_RESET;
            cur_ff.primary <= agent_request_interrupt_first_n_i;
            cur_ff.int_prev[0] <= ~agent_request_interrupt_first_n_i;
            cur_ff.init_self <= bad_access_input_n_i;
            // reset length is the system's duty
        end else begin
            cur_ff <= nxt_ff;
            cur_ff.primary <= cur_ff.primary;
            cur_ff.init_self <= cur_ff.init_self;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs, all straight from the state register
    // -------------------------------------------------------------------------
    assign req_ready_o = cur_ff.req_ready;
    assign read_data_o = cur_ff.rdata;
    assign read_data_valid_o = cur_ff.rvalid;
    assign done_o = cur_ff.done;
    assign bus_error_o = cur_ff.berr;
    assign address_data_lines_o = cur_ff.address_data_lines.value;
    assign address_data_lines_oe_o = cur_ff.address_data_lines.enable;
    assign address_latch_enable_n_o = cur_ff.ale_n;
    assign address_latch_enable_oe_o = cur_ff.ale_oe;
    assign address_strobe_n_o = cur_ff.ads_n;
    assign write_read_o = cur_ff.wr;
    assign transfer_direction_o = cur_ff.dir;
    assign data_enable_strobe_n_o = cur_ff.den_n;
    assign lock_n_oe_o = cur_ff.lock_held;
    assign byte_enables_n_o = cur_ff.be_n;
    assign hold_grant_or_request_out_o = cur_ff.hold_out;
    assign hold_grant_or_request_out_oe_o = cur_ff.hold_oe;
    assign cache_o = cur_ff.cache;
    assign cache_oe_o = cur_ff.cache_oe;
    assign failure_n_o = cur_ff.fail_n;
    assign interrupt_fourth_or_acknowledge_oe_o = cur_ff.inta_oe;
    assign primary_master_role_o = cur_ff.primary;
    assign local_number_o = ~cur_ff.primary;
    assign performs_init_o = cur_ff.init_self;
    assign interrupt_event_o = cur_ff.int_evt;
    assign controller_request_o = cur_ff.ctrl_req;
endmodule : local_bus_interface

//--- local_bus_pkg.sv
// Purpose: Shared types and constants for the local bus interface.
// Assumes: One 200 MHz clock, synchronous active-low reset.
// Notes: Tri-state pins travel as value plus enable; open-drain pins travel as enable alone.
package local_bus_pkg;
    // -------------------------------------------------------------------------
    // Encodings and counts
    // -------------------------------------------------------------------------
    // Burst length code on the two low address/data bits.
    localparam logic [1:0] SIZE_ONE_WORD = 2'h0;
    localparam logic [1:0] SIZE_FOUR_WORDS = 2'h3;
    // Reset value of the word counter.
    localparam logic [1:0] BEAT_RESET = 2'h0;
    // Self-test duration in clock cycles, kept short and named.
    localparam logic [7:0] SELF_TEST_CYCLES = 8'h20;
    // Number of words summed by the boot checksum.
    localparam logic [3:0] CHECKSUM_WORDS = 4'h8;
    // All byte enables deasserted (active low).
    localparam logic [3:0] BYTE_ENABLES_IDLE = 4'hf;

    // Bus cycle states, Gray coded along idle, address, data, recover.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_DATA = 3'h3,
        ST_RECOVER = 3'h2,
        ST_HOLD = 3'h6
    } bus_state_t;

    // Boot sequence phases.
    typedef enum logic [1:0] {
        BOOT_TEST = 2'h0,
        BOOT_SUM = 2'h1,
        BOOT_RUN = 2'h3,
        BOOT_FAIL = 2'h2
    } boot_state_t;

    // One request from the core side.
    typedef struct packed {
        logic [29:0] word_addr;
        logic [1:0] size;
        logic write;
        logic locked_read_modify_write;
        logic rmw_write;
        logic int_ack;
        logic cacheable;
        logic synchronous;
    } bus_req_t;

    // One tri-state pin set: value and enable.
    typedef struct packed {
        logic [31:0] value;
        logic enable;
    } bus_word_drive_t;
endpackage : local_bus_pkg

//--- local_bus_properties.sv
// Purpose: Cycle checks on the local bus pins.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into the interface; sees its ports only.
`timescale 1ns/1ps
module local_bus_properties
    import local_bus_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire bus_req_t req_i,
    input wire logic ready_n_i,
    input wire logic [31:0] address_data_lines_o,
    input wire logic address_data_lines_oe_o,
    input wire logic address_latch_enable_n_o,
    input wire logic address_latch_enable_oe_o,
    input wire logic address_strobe_n_o,
    input wire logic transfer_direction_o,
    input wire logic data_enable_strobe_n_o,
    input wire logic [3:0] byte_enables_n_o,
    input wire logic cache_o
);
    // Phases decoded from the pins; a floated latch enable is not an address cycle.
    wire logic addr_cycle = !address_latch_enable_n_o && address_latch_enable_oe_o;
    wire logic data_cycle = !data_enable_strobe_n_o;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_size_code: assert property (addr_cycle |-> address_data_lines_o[1:0] == req_i.size)
        else $error("wrong burst code");
    chk_strobe_addr: assert property (addr_cycle |-> !address_strobe_n_o ##1 address_strobe_n_o)
        else $error("strobe wrong around address");
    chk_dir_steady: assert property (data_cycle ##1 data_cycle |-> $stable(transfer_direction_o))
        else $error("direction moved in data");
    chk_wait_quiet: assert property (data_cycle && ready_n_i |=> address_strobe_n_o)
        else $error("strobe after wait");
    chk_lanes_held: assert property (data_cycle && ready_n_i ##1 data_cycle |-> $stable(byte_enables_n_o))
        else $error("lanes moved in wait");
    chk_be_legal: assert property (addr_cycle |->
        byte_enables_n_o inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0}) else $error("illegal lanes");
    chk_sync_uncached: assert property (addr_cycle && req_i.synchronous |-> !cache_o)
        else $error("synchronous access cached");
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> address_strobe_n_o &&
        data_enable_strobe_n_o && !address_data_lines_oe_o && byte_enables_n_o == BYTE_ENABLES_IDLE)
        else $error("pins active in reset");
endmodule : local_bus_properties

bind local_bus_interface local_bus_properties i_props (.clk_i, .rst_n_i, .req_i, .ready_n_i,
    .address_data_lines_o, .address_data_lines_oe_o, .address_latch_enable_n_o, .address_latch_enable_oe_o,
    .address_strobe_n_o, .transfer_direction_o, .data_enable_strobe_n_o, .byte_enables_n_o, .cache_o);

//--- testbench.sv
// Purpose: Self-checking bench for the local bus interface.
// Assumes: Memory partner on the far side.
// Notes: Requests and reset move on the rising edge; other inputs move, and outputs are read, on the falling one.
`timescale 1ns/1ps
module testbench
    import local_bus_pkg::*;
;
    logic clk_i, rst_n_i, req_valid_i, ready_n_i, lock_n_i, bad_access_input_n_i, lock_busy, bad_req, seen;
    bus_req_t req_i;
    logic [3:0] first_byte_enables_n_i, next_byte_enables_n_i, byte_enables_n_o, interrupt_event_o, irq_on;
    logic [31:0] write_data_i, next_write_data_i, read_data_o, address_data_lines_i, address_data_lines_o;
    logic third_is_controller_request_i, fourth_is_acknowledge_i, self_test_pass_i, checksum_done_i;
    logic checksum_zero_i, req_ready_o, read_data_valid_o, done_o, bus_error_o, address_data_lines_oe_o;
    logic address_latch_enable_n_o, address_latch_enable_oe_o, address_strobe_n_o, write_read_o;
    logic transfer_direction_o, data_enable_strobe_n_o, lock_n_oe_o, hold_request_or_grant_in_i;
    logic hold_grant_or_request_out_o, hold_grant_or_request_out_oe_o, cache_o, cache_oe_o, failure_n_o;
    logic interrupt_fourth_or_acknowledge_oe_o, primary_master_role_o, local_number_o, performs_init_o;
    logic controller_request_o, agent_request_interrupt_first_n_i, interrupt_second_i;
    logic interrupt_third_or_controller_request_i, interrupt_fourth_or_acknowledge_n_i;
    logic [1:0] waits;
    logic [31:0] exp_mem [16];
    int failures, checks_done;
    // Interrupt sources; open-drain pins resolve with the device's own pull.
    assign agent_request_interrupt_first_n_i = !irq_on[0];
    assign interrupt_second_i = irq_on[1];
    assign interrupt_third_or_controller_request_i = irq_on[2];
    assign interrupt_fourth_or_acknowledge_n_i = !(irq_on[3] || interrupt_fourth_or_acknowledge_oe_o);
    assign lock_n_i = !(lock_n_oe_o || lock_busy);
    local_bus_interface i_dut (.*);
    lbus_memory_model i_mem (.clk_i, .rst_n_i, .bus_out_i(address_data_lines_o), .bus_oe_i(address_data_lines_oe_o),
        .strobe_n_i(address_strobe_n_o), .data_enable_n_i(data_enable_strobe_n_o), .write_i(write_read_o),
        .wait_cycles_i(waits), .bad_req_i(bad_req), .bus_in_o(address_data_lines_i), .ready_n_o(ready_n_i),
        .bad_n_o(bad_access_input_n_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Bounded wait for a level; running out ends the run.
    task automatic wait_for(ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        check(n < 200, "wait ran out");
        if (n >= 200) complete_run();
    endtask : wait_for
    // One transaction; read words are compared as they arrive.
    task automatic xfer(input bus_req_t r, input logic [3:0] be, input logic [1:0] w, input logic bad);
        int k;
        k = 0;
        @(posedge clk_i);
        req_i <= r;
        req_valid_i <= 1'b1;
        first_byte_enables_n_i <= be;
        next_byte_enables_n_i <= be;
        waits <= w;
        bad_req <= bad;
        wait_for(req_ready_o, 1'b1);
        check(address_data_lines_o === {r.word_addr, r.size} && byte_enables_n_o === be, "address");
        check({write_read_o, transfer_direction_o, cache_o, lock_n_oe_o} === {r.write, r.write,
            r.cacheable && !r.synchronous, r.locked_read_modify_write || r.int_ack} &&
            interrupt_fourth_or_acknowledge_oe_o === (r.int_ack && fourth_is_acknowledge_i), "qualifiers");
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        for (int n = 0; n < 100 && done_o !== 1'b1; n++) begin
            @(negedge clk_i);
            if (read_data_valid_o === 1'b1) begin
                check(read_data_o === exp_mem[r.word_addr[3:0] + k], "read data");
                k++;
            end
        end
        check(done_o === 1'b1 && bus_error_o === bad && k == (r.write ? 0 : r.size + 1), "end");
        if (done_o !== 1'b1) complete_run();
        for (int i = 0; r.write && i <= r.size; i++)
            exp_mem[r.word_addr[3:0] + i] = (i == 0) ? write_data_i : next_write_data_i;
    endtask : xfer
    initial begin
        failures = 0;
        checks_done = 0;
        {rst_n_i, req_valid_i, third_is_controller_request_i, fourth_is_acknowledge_i} = 4'h0;
        {self_test_pass_i, checksum_done_i, checksum_zero_i} = 3'h7;
        {hold_request_or_grant_in_i, lock_busy, bad_req, waits, irq_on} = 9'h0;
        {req_i, first_byte_enables_n_i, next_byte_enables_n_i, write_data_i, next_write_data_i} = '0;
        for (int i = 0; i < 16; i++) exp_mem[i] = 32'ha5a50000 + i;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        check(primary_master_role_o === 1'b1 && local_number_o === 1'b0, "role");
        check(performs_init_o === 1'b1, "init strap");
        check(failure_n_o === 1'b0, "self test");
        wait_for(failure_n_o, 1'b1);
        for (int s = 0; s < 4; s++) xfer('{word_addr: 30'(4 * s), size: 2'(s), default: 1'b0}, 4'h0, 2'(s), 1'b0);
        xfer('{word_addr: 30'h1, cacheable: 1'b1, synchronous: 1'b1, default: 1'b0}, 4'hc, 2'h1, 1'b1);
        write_data_i <= 32'h1234abcd;
        next_write_data_i <= 32'hfedc0987;
        xfer('{word_addr: 30'h2, size: 2'h1, write: 1'b1, default: 1'b0}, 4'h0, 2'h1, 1'b0);
        xfer('{word_addr: 30'h2, size: 2'h1, default: 1'b0}, 4'h0, 2'h0, 1'b0);
        lock_busy <= 1'b1;
        fork
            xfer('{word_addr: 30'h5, locked_read_modify_write: 1'b1, default: 1'b0}, 4'h0, 2'h0, 1'b0);
            begin
                repeat (10) begin
                    @(negedge clk_i);
                    check(req_ready_o === 1'b0, "taken under lock");
                end
                lock_busy <= 1'b0;
            end
        join
        check(lock_n_oe_o === 1'b1, "lock dropped");
        xfer('{word_addr: 30'h5, write: 1'b1, rmw_write: 1'b1, default: 1'b0}, 4'h0, 2'h0, 1'b0);
        check(lock_n_oe_o === 1'b0, "lock kept");
        third_is_controller_request_i <= 1'b1;
        fourth_is_acknowledge_i <= 1'b1;
        irq_on[2] <= 1'b1;
        xfer('{word_addr: 30'h6, int_ack: 1'b1, default: 1'b0}, 4'h0, 2'h0, 1'b0);
        check(lock_n_oe_o === 1'b0 && controller_request_o === 1'b1, "after acknowledge");
        {third_is_controller_request_i, fourth_is_acknowledge_i, irq_on[2]} <= 3'h0;
        hold_request_or_grant_in_i <= 1'b1;
        wait_for(hold_grant_or_request_out_o, 1'b1);
        check(address_data_lines_oe_o === 1'b0 && hold_grant_or_request_out_oe_o === 1'b1, "hold");
        hold_request_or_grant_in_i <= 1'b0;
        wait_for(hold_grant_or_request_out_o, 1'b0);
        for (int p = 0; p < 4; p++) begin
            seen = 1'b0;
            irq_on[p] <= 1'b1;
            repeat (8) begin
                @(negedge clk_i);
                seen = seen | interrupt_event_o[p];
            end
            irq_on[p] <= 1'b0;
            check(seen, "interrupt");
        end
        complete_run();
    end
endmodule : testbench
